//--- src/dmar_top.sv
// data memory access router: on-chip sram, external muxed bus, sfr decode
`timescale 1ns/100ps
module dmar_top (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic onchip_xram_enable_set_i,
    input wire logic onchip_xram_enable_clr_i,
    input wire logic [3:0] access_len_i,
    input wire logic access_len_we_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [15:0] req_addr_i,
    input wire logic [7:0] req_wdata_i,
    output logic req_ready_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic onchip_xram_enable_o,
    output logic mcycle_strobe_o,
    input wire logic code_space_read_i,
    input wire logic [7:0] gpio_low_out_i,
    input wire logic [7:0] low_addr_data_port_i,
    output logic [7:0] low_addr_data_port_o,
    output logic [7:0] low_addr_data_port_oe_n_o,
    output logic [7:0] high_address_port_o,
    output logic high_address_port_drive_o,
    output logic addr_latch_o,
    output logic write_strobe_n_o,
    output logic read_strobe_n_o,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_indirect_i,
    input wire logic sfr_bit_access_i,
    input wire logic [7:0] sfr_impl_mask_i,
    input wire logic [7:0] sfr_raw_data_i,
    output logic sfr_sel_o,
    output logic scratch_sel_o,
    output logic sfr_bit_ok_o,
    output logic [7:0] sfr_rdata_o
);
    import dmar_pkg::*;

    dmar_state_e state_q;
    logic [1:0] phase_q;
    logic [3:0] mc_cnt_q;
    logic [3:0] access_len_q;
    logic en_q;
    logic wr_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic done_q;
    logic sram_we;
    logic [7:0] sram_rdata;
    logic mc_end;
    logic bus_active;

    // true when an address is served on chip
    function automatic logic is_local(input logic en, input logic [15:0] a);
        return en && (a <= ONCHIP_TOP);
    endfunction : is_local

    // four clocks make one machine cycle; phase counter free runs
    always_ff @(posedge clock_i) begin
        if (rst_i) phase_q <= 2'h0;
        else phase_q <= phase_q + 2'h1;
    end
    assign mc_end = (phase_q == 2'(CLKS_PER_MCYCLE - 1));
    assign mcycle_strobe_o = mc_end;

    // enable bit; set wins over clear
    always_ff @(posedge clock_i) begin
        if (rst_i) en_q <= 1'b0;
        else if (onchip_xram_enable_set_i) en_q <= 1'b1;
        else if (onchip_xram_enable_clr_i) en_q <= 1'b0;
    end
    assign onchip_xram_enable_o = en_q;

    // access length clamped into the legal window
    always_ff @(posedge clock_i) begin
        if (rst_i) access_len_q <= ACCESS_LEN_RST;
        else if (access_len_we_i) begin
            if (access_len_i < MIN_ACCESS_MC) access_len_q <= MIN_ACCESS_MC;
            else if (access_len_i > MAX_ACCESS_MC) access_len_q <= MAX_ACCESS_MC;
            else access_len_q <= access_len_i;
        end
    end

    // access sequencer; external data phases start on a machine-cycle edge
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_q <= DMAR_IDLE;
            mc_cnt_q <= 4'h0;
            wr_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
        end else begin
            case (state_q)
                DMAR_IDLE: begin
                    if (req_i) begin
                        wr_q <= req_write_i;
                        addr_q <= req_addr_i;
                        wdata_q <= req_wdata_i;
                        mc_cnt_q <= 4'h0;
                        if (is_local(en_q, req_addr_i)) state_q <= DMAR_LOCAL;
                        else state_q <= DMAR_ADDR;
                    end
                end
                DMAR_ADDR: begin
                    // address phase lasts to a machine-cycle boundary; a take that lands
                    // on the boundary clock waits one more machine cycle so the latch still pulses
                    if (!mc_end) mc_cnt_q <= 4'h1;
                    else if (mc_cnt_q != 4'h0) state_q <= DMAR_DATA;
                end
                DMAR_DATA: begin
                    if (mc_end) begin
                        if (mc_cnt_q + 4'h1 >= access_len_q) state_q <= DMAR_DONE;
                        else mc_cnt_q <= mc_cnt_q + 4'h1;
                    end
                end
                DMAR_LOCAL: state_q <= DMAR_DONE;
                DMAR_DONE: state_q <= DMAR_IDLE;
                default: state_q <= DMAR_IDLE;
            endcase
        end
    end

    assign req_ready_o = (state_q == DMAR_IDLE);
    assign sram_we = (state_q == DMAR_LOCAL) && wr_q;

    dmar_sram #(.AW(ONCHIP_AW)) u_sram (
        .clock_i(clock_i),
        .we_i(sram_we),
        .addr_i(addr_q[ONCHIP_AW-1:0]),
        .wdata_i(wdata_q),
        .rdata_o(sram_rdata)
    );

    // read data capture: external bus sampled on the last data clock
    always_ff @(posedge clock_i) begin
        if (rst_i) rdata_q <= 8'h00;
        else if (state_q == DMAR_DATA && !wr_q && mc_end
                 && mc_cnt_q + 4'h1 >= access_len_q) rdata_q <= low_addr_data_port_i;
        else if (state_q == DMAR_DONE && !wr_q && is_local(en_q, addr_q)) rdata_q <= sram_rdata;
    end

    // completion pulse one clock after the done state
    always_ff @(posedge clock_i) begin
        if (rst_i) done_q <= 1'b0;
        else done_q <= (state_q == DMAR_DONE);
    end
    assign done_o = done_q;
    assign rdata_o = rdata_q;

    // external pin drive; on-chip accesses leave the bus idle
    assign bus_active = (state_q == DMAR_ADDR) || (state_q == DMAR_DATA);
    assign addr_latch_o = (state_q == DMAR_ADDR) && (phase_q != 2'h3);
    assign write_strobe_n_o = !((state_q == DMAR_DATA) && wr_q);
    assign read_strobe_n_o = !((state_q == DMAR_DATA) && !wr_q);
    assign high_address_port_o = bus_active ? addr_q[15:8] : 8'h00;
    assign high_address_port_drive_o = bus_active || code_space_read_i;

    // low port: full push-pull in bus use, open drain otherwise
    always_comb begin
        low_addr_data_port_o = 8'h00;
        low_addr_data_port_oe_n_o = 8'hff;
        if (state_q == DMAR_ADDR) begin
            low_addr_data_port_o = addr_q[7:0];
            low_addr_data_port_oe_n_o = 8'h00;
        end else if (state_q == DMAR_DATA) begin
            low_addr_data_port_o = wdata_q;
            low_addr_data_port_oe_n_o = wr_q ? 8'h00 : 8'hff;
        end else if (!code_space_read_i) begin
            low_addr_data_port_oe_n_o = gpio_low_out_i; // drive low only on a zero
        end
    end

    // sfr and scratchpad decode; indirect never reaches the sfr space
    always_comb begin
        sfr_sel_o = !sfr_indirect_i && (sfr_addr_i >= SFR_BASE);
        scratch_sel_o = !sfr_sel_o;
        sfr_bit_ok_o = sfr_sel_o && sfr_bit_access_i && (sfr_addr_i[2:0] == 3'h0);
        sfr_rdata_o = (sfr_raw_data_i & sfr_impl_mask_i) | (UNIMPL_READ & ~sfr_impl_mask_i);
    end

    a_enable_reset: assert property (@(posedge clock_i) rst_i |=> !en_q)
        else $error("enable not cleared by reset");
    a_local_no_strobe: assert property (@(posedge clock_i) disable iff (rst_i)
        state_q == DMAR_LOCAL |-> read_strobe_n_o && write_strobe_n_o)
        else $error("strobe during on-chip access");
    a_disabled_external: assert property (@(posedge clock_i) disable iff (rst_i)
        req_ready_o && req_i && !en_q |=> state_q == DMAR_ADDR)
        else $error("disabled access not external");
    a_high_local: assert property (@(posedge clock_i) disable iff (rst_i)
        req_ready_o && req_i && en_q && req_addr_i > ONCHIP_TOP |=> state_q == DMAR_ADDR)
        else $error("high address not external");
    a_low_local: assert property (@(posedge clock_i) disable iff (rst_i)
        req_ready_o && req_i && en_q && req_addr_i <= ONCHIP_TOP |=> state_q == DMAR_LOCAL)
        else $error("low address not on chip");
    a_phase_wrap: assert property (@(posedge clock_i) disable iff (rst_i)
        mc_end |=> phase_q == 2'h0 ##3 mc_end)
        else $error("machine cycle not four clocks");
    a_access_len: assert property (@(posedge clock_i) disable iff (rst_i)
        access_len_q >= MIN_ACCESS_MC && access_len_q <= MAX_ACCESS_MC)
        else $error("access length out of range");
    a_latch_first: assert property (@(posedge clock_i) disable iff (rst_i)
        addr_latch_o |-> read_strobe_n_o && write_strobe_n_o
        && low_addr_data_port_o == addr_q[7:0])
        else $error("latch overlaps data phase");
    a_latch_before_data: assert property (@(posedge clock_i) disable iff (rst_i)
        $rose(state_q == DMAR_DATA) |-> $past(addr_latch_o, 2))
        else $error("data phase without latch pulse");
    a_indirect_sfr: assert property (@(posedge clock_i) sfr_indirect_i |-> !sfr_sel_o)
        else $error("indirect access hit sfr");
    a_bit_align: assert property (@(posedge clock_i) sfr_bit_ok_o |-> sfr_sel_o
        && sfr_bit_access_i && sfr_addr_i[3:0] inside {4'h0, 4'h8})
        else $error("bit access on unaligned sfr");

    c_ext_read: cover property (@(posedge clock_i) state_q == DMAR_DATA && !wr_q ##[1:40] done_o);
    c_ext_write: cover property (@(posedge clock_i) state_q == DMAR_DATA && wr_q ##[1:40] done_o);
    c_local: cover property (@(posedge clock_i) state_q == DMAR_LOCAL ##2 done_o);
endmodule : dmar_top

//--- shared/dmar_pkg.sv
// constants and types shared by the data memory access router
// Notes on behaviour
// - machine cycle spans four input clocks
// - external access length two to nine cycles
// - on-chip sram at 0000h-03ffh, data only
// - enabled sram serves low 1 KB accesses
// - reset clears the on-chip sram enable
// - enabled: addresses above 03ffh go external
// - disabled: all addresses go to external bus
// - low port muxed bus, else open drain
// - high port drives upper address byte
// - scratchpad has its own 256-byte space
// - sfrs at 80h-ffh, direct addressing only
// - bit access only where address ends 0/8
// - unimplemented sfr bits read as one
// - latch strobe pulses before data phase
// - active-low write strobe on external writes
// - active-low read strobe on external reads
package dmar_pkg;
    localparam int CLKS_PER_MCYCLE = 4;
    localparam logic [3:0] MIN_ACCESS_MC = 4'h2;
    localparam logic [3:0] MAX_ACCESS_MC = 4'h9;
    localparam logic [15:0] ONCHIP_TOP = 16'h03ff;
    localparam int ONCHIP_AW = 10;
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [7:0] UNIMPL_READ = 8'hff;
    localparam logic [3:0] ACCESS_LEN_RST = 4'h9;
    typedef enum logic [2:0] {
        DMAR_IDLE, DMAR_ADDR, DMAR_DATA, DMAR_LOCAL, DMAR_DONE
    } dmar_state_e;
endpackage : dmar_pkg

//--- src/dmar_sram.sv
// on-chip 1 KB data sram built from flip-flops
`timescale 1ns/100ps
module dmar_sram #(
    parameter int AW = 10
) (
    input wire logic clock_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [0:(1<<AW)-1];

    // write port, storage holds no reset so contents survive a soft reset
    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    // registered read port
    always_ff @(posedge clock_i) begin
        rdata_o <= mem_q[addr_i];
    end
endmodule : dmar_sram

//--- sim/dmar_ext_ram.sv
// behavioural external data ram on the muxed low and high address ports
`timescale 1ns/100ps
module dmar_ext_ram (
    input wire logic clock_i,
    input wire logic addr_latch_i,
    input wire logic [7:0] low_port_i,
    input wire logic [7:0] low_oe_n_i,
    input wire logic [7:0] high_port_i,
    input wire logic write_strobe_n_i,
    input wire logic read_strobe_n_i,
    output logic [7:0] pin_o
);
    logic [7:0] mem [0:65535];
    logic [15:0] addr_q;
    logic [7:0] last_q;
    // capture address while the latch strobe is high, store on write strobe
    always_ff @(posedge clock_i) begin
        if (addr_latch_i) addr_q <= {high_port_i, pin_o};
        if (!write_strobe_n_i) mem[addr_q] <= pin_o;
        last_q <= pin_o;
    end
    // wire level: design where enabled, ram on read, else inverse of last value
    // so a released bus never passes for the byte it last carried
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!low_oe_n_i[i]) pin_o[i] = low_port_i[i];
            else if (!read_strobe_n_i) pin_o[i] = mem[addr_q][i];
            else pin_o[i] = ~last_q[i];
        end
    end
endmodule : dmar_ext_ram

//--- sim/tb_top.sv
// self-checking bench for the data memory access router
`timescale 1ns/100ps
module tb_top;
    import dmar_pkg::*;
    logic clock_i = 0, rst_i = 1, en_set = 0, en_clr = 0, len_we = 0, req = 0, req_wr = 0;
    logic [3:0] len = 4'h9;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_wd = 8'h00, gpio = 8'h5a, sfr_a = 8'h00, mask = 8'h0f, raw = 8'h00;
    logic sfr_ind = 0, sfr_bit = 1, ready, done, en_o, mc, hi_drv, ale, wr_n, rd_n;
    logic sfr_sel, scr_sel, bit_ok;
    logic csr = 0;
    logic [7:0] rdata, port_o, oe_n, hi, sfr_rd, pin, hi_seen;
    int n_errors = 0, cmp_count = 0, wr_cnt, rd_cnt, mc_cnt, ale_cnt;
    dmar_top dut (.clock_i(clock_i), .rst_i(rst_i), .onchip_xram_enable_set_i(en_set),
        .onchip_xram_enable_clr_i(en_clr), .access_len_i(len), .access_len_we_i(len_we),
        .req_i(req), .req_write_i(req_wr), .req_addr_i(req_addr), .req_wdata_i(req_wd),
        .req_ready_o(ready), .done_o(done), .rdata_o(rdata), .onchip_xram_enable_o(en_o),
        .mcycle_strobe_o(mc), .code_space_read_i(csr), .gpio_low_out_i(gpio),
        .low_addr_data_port_i(pin), .low_addr_data_port_o(port_o),
        .low_addr_data_port_oe_n_o(oe_n), .high_address_port_o(hi),
        .high_address_port_drive_o(hi_drv), .addr_latch_o(ale), .write_strobe_n_o(wr_n),
        .read_strobe_n_o(rd_n), .sfr_addr_i(sfr_a), .sfr_indirect_i(sfr_ind),
        .sfr_bit_access_i(sfr_bit), .sfr_impl_mask_i(mask), .sfr_raw_data_i(raw),
        .sfr_sel_o(sfr_sel), .scratch_sel_o(scr_sel), .sfr_bit_ok_o(bit_ok),
        .sfr_rdata_o(sfr_rd));
    dmar_ext_ram ram (.clock_i(clock_i), .addr_latch_i(ale), .low_port_i(port_o),
        .low_oe_n_i(oe_n), .high_port_i(hi), .write_strobe_n_i(wr_n),
        .read_strobe_n_i(rd_n), .pin_o(pin));
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    // count strobes mid-cycle, where comb outputs have settled
    always @(negedge clock_i) begin
        if (!wr_n) wr_cnt++;
        if (!rd_n) rd_cnt++;
        if (mc) mc_cnt++;
        if (ale) ale_cnt++;
        if (ale && hi_drv) hi_seen = hi;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // one whole transfer: request held until the taking edge, then wait for done
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
        wr_cnt = 0; rd_cnt = 0; ale_cnt = 0; hi_seen = 8'h00;
        req = 1; req_wr = w; req_addr = a; req_wd = d;
        @(posedge clock_i);
        #1 req = 0;
        for (int k = 0; k < 100 && done !== 1'b1; k++) begin
            @(posedge clock_i);
            #1;
        end
        chk8({7'h00, done}, 8'h01);
    endtask : access
    task automatic pulse(ref logic s);
        s = 1;
        @(posedge clock_i);
        #1 s = 0;
    endtask : pulse
    task automatic t_reset();
        chk8({7'h00, en_o}, 8'h00);
        chk8({6'h00, wr_n, rd_n}, 8'h03);
        chk8(oe_n, gpio);
        chk8({7'h00, hi_drv}, 8'h00);
        csr = 1;
        #1;
        chk8(oe_n, 8'hff);
        chk8({7'h00, hi_drv}, 8'h01);
        csr = 0;
        mc_cnt = 0;
        repeat (8) @(posedge clock_i);
        #1;
        chk8(8'(mc_cnt), 8'h02);
    endtask : t_reset
    // five length codes, clamped ends included, on the external bus
    task automatic t_ext_len();
        logic [3:0] lv [5] = '{4'h0, 4'h2, 4'h5, 4'h9, 4'hf};
        logic [3:0] cl;
        foreach (lv[i]) begin
            cl = (lv[i] < MIN_ACCESS_MC) ? MIN_ACCESS_MC : lv[i];
            cl = (cl > MAX_ACCESS_MC) ? MAX_ACCESS_MC : cl;
            len = lv[i];
            pulse(len_we);
            access(1, {4'h8, lv[i], 8'h21}, {4'ha, lv[i]});
            chk8(8'(wr_cnt), 8'((cl - 1) * CLKS_PER_MCYCLE));
            chk8(hi_seen, {4'h8, lv[i]});
            chk8(8'(ale_cnt > 0), 8'h01);
            access(0, {4'h8, lv[i], 8'h21}, 8'h00);
            chk8(8'(rd_cnt), 8'((cl - 1) * CLKS_PER_MCYCLE));
            chk8(rdata, {4'ha, lv[i]});
        end
    endtask : t_ext_len
    // same low address served externally, then on chip, then externally again
    task automatic t_onchip();
        access(1, 16'h0010, 8'h3c);
        pulse(en_set);
        chk8({7'h00, en_o}, 8'h01);
        access(1, 16'h0010, 8'hc3);
        chk8(8'(wr_cnt + ale_cnt), 8'h00);
        access(0, 16'h0010, 8'h00);
        chk8(rdata, 8'hc3);
        access(1, ONCHIP_TOP, 8'h96);
        access(0, ONCHIP_TOP, 8'h00);
        chk8(rdata, 8'h96);
        chk8(8'(rd_cnt), 8'h00);
        access(1, 16'h0400, 8'h69);
        chk8(hi_seen, 8'h04);
        pulse(en_clr);
        access(0, 16'h0010, 8'h00);
        chk8(rdata, 8'h3c);
    endtask : t_onchip
    // mid-run reset drops the enable and the access length back to reset values
    task automatic t_midreset();
        pulse(en_set);
        len = MIN_ACCESS_MC;
        pulse(len_we);
        pulse(rst_i);
        chk8({7'h00, en_o}, 8'h00);
        access(1, 16'h0020, 8'h55);
        chk8(8'(wr_cnt), 8'((ACCESS_LEN_RST - 1) * CLKS_PER_MCYCLE));
        chk8(8'(ale_cnt > 0), 8'h01);
        access(0, 16'h0020, 8'h00);
        chk8(rdata, 8'h55);
    endtask : t_midreset
    // direct and indirect decode over both spaces and bit-access addresses
    task automatic t_sfr();
        logic [7:0] av [5] = '{8'h7f, SFR_BASE, 8'h88, 8'h8f, 8'hf8};
        logic sel_exp, bit_exp;
        for (int j = 0; j < 15; j++) begin
            sfr_a = av[j % 5];
            sfr_ind = (j >= 5) && (j < 10);
            sfr_bit = (j < 10);
            sel_exp = sfr_a[7] & !sfr_ind;
            bit_exp = sel_exp & sfr_bit & (sfr_a[3:0] inside {4'h0, 4'h8});
            #1;
            chk8({7'h00, sfr_sel}, {7'h00, sel_exp});
            chk8({7'h00, scr_sel}, {7'h00, !sel_exp});
            chk8({7'h00, bit_ok}, {7'h00, bit_exp});
        end
        chk8(sfr_rd, 8'hf0);
        raw = 8'ha5;
        #1;
        chk8(sfr_rd, 8'hf5);
    endtask : t_sfr
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clock_i);
        #1 rst_i = 0;
        t_reset();
        t_ext_len();
        t_onchip();
        t_midreset();
        t_sfr();
        tally_and_finish();
    end
endmodule : tb_top
